// ==== bench/apb_flash_command_issue_bench.sv ====
// Self-checking bench for the APB flash command block.
// Assumes default widths; the flash model answers on the same clock.
`default_nettype none
module apb_flash_command_issue_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] ID = 8'h3C;
  localparam logic [31:0] RD = 32'hC0DE_0001;
  logic clk_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic ready_en = 1'b1, fail_en = 1'b0, e, pready_o, pslverr_o, fready_i, fdone_i, ffail_i;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, r, prdata_o, faddr_o, fwdata_o, frdata_i;
  logic [4:0] fcmd_o;
  int miscompares = 0, check_count = 0;
  apb_flash_command_issue #(.PREAMBLE_SEGMENT_FOUR(ID)) apb_flash_command_issue_inst (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .fready_i(fready_i), .fdone_i(fdone_i),
    .ffail_i(ffail_i), .frdata_i(frdata_i), .fcmd_o(fcmd_o), .faddr_o(faddr_o),
    .fwdata_o(fwdata_o));
  flash_bus_model #(.LAT(32), .RDATA(RD)) flash_bus_model_inst (.clk_i(clk_i), .reset_i(reset_i),
    .ready_en_i(ready_en), .fail_en_i(fail_en), .fcmd_i(fcmd_o), .fready_o(fready_i),
    .fdone_o(fdone_i), .ffail_o(ffail_i), .frdata_o(frdata_i));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 8);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic clear;
    apb(1'b1, 12'h014, 32'h0000_001F);
    rd(12'h014);
    chk("cleared flags", 32'h0, r);
  endtask
  task automatic settle;
    int n = 0;
    rd(12'h00C);
    while (r !== 32'h0 && n < 40) begin
      rd(12'h00C);
      n++;
    end
  endtask
  task automatic t_ident;
    rd(12'hFFC);
    chk("id word", {24'h0, ID}, r);
    rd(12'h020);
    chk("unmapped error", 32'h1, {31'h0, e});
  endtask
  task automatic t_block;
    ready_en <= 1'b0;
    apb(1'b1, 12'h004, 32'h0000_0040);
    apb(1'b1, 12'h000, 32'h0000_0002);
    apb(1'b1, 12'h000, 32'h0000_0003);
    apb(1'b1, 12'h004, 32'h0000_0080);
    rd(12'h00C);
    chk("status queued", 32'h1, {31'h0, r[0]});
    rd(12'h010);
    chk("reject flag", 32'h4, r);
    chk("held command", 32'h2, {27'h0, fcmd_o});
    chk("held address", 32'h40, faddr_o);
    clear;
    ready_en <= 1'b1;
    settle;
    rd(12'h010);
    chk("accept flags", 32'h9, r);
    clear;
  endtask
  // Second row write queued while the first still executes
  task automatic t_preload;
    apb(1'b1, 12'h004, 32'h0000_00A0);
    apb(1'b1, 12'h008, 32'h0000_0D00);
    apb(1'b1, 12'h000, 32'h0000_0003);
    rd(12'h010);
    chk("first accept", 32'h8, r);
    clear;
    apb(1'b1, 12'h004, 32'h0000_00A1);
    apb(1'b1, 12'h008, 32'h0000_0D01);
    apb(1'b1, 12'h000, 32'h0000_0003);
    #1;
    chk("preloaded command", 32'h3, {27'h0, fcmd_o});
    chk("preloaded address", 32'hA1, faddr_o);
    chk("preloaded data", 32'hD01, fwdata_o);
    rd(12'h00C);
    chk("status preload", 32'h3, r);
    settle;
    rd(12'h010);
    chk("preload flags", 32'h9, r);
    clear;
  endtask
  task automatic t_cmd(input logic [4:0] c, input logic f, input logic [4:0] fl);
    fail_en <= f;
    apb(1'b1, 12'h004, {27'h0, c});
    apb(1'b1, 12'h008, ~{27'h0, c});
    apb(1'b1, 12'h000, {27'h0, c});
    #1;
    chk("issued command", {27'h0, c}, {27'h0, fcmd_o});
    chk("issued address", {27'h0, c}, faddr_o);
    chk("issued data", ~{27'h0, c}, fwdata_o);
    rd(12'h00C);
    chk("status busy", 32'h1, {31'h0, r != 32'h0});
    settle;
    rd(12'h010);
    chk("done flags", {27'h0, fl}, r);
    if (c == 5'h01 && !f) begin
      rd(12'h018);
      chk("read data", RD, r);
    end
    clear;
  endtask
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    t_ident;
    t_block;
    t_preload;
    t_cmd(5'h01, 1'b0, 5'h19);
    t_cmd(5'h02, 1'b0, 5'h09);
    t_cmd(5'h03, 1'b1, 5'h0A);
    print_verdict;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    print_verdict;
  end
endmodule
`default_nettype wire

// ==== bench/flash_bus_model.sv ====
// Flash side bus model: takes a command, finishes it LAT cycles later.
// Assumes the block's clock; one command in execution at a time.
`default_nettype none
module flash_bus_model #(
  parameter int LAT = 8,
  parameter logic [31:0] RDATA = 32'h1234_ABCD
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ready_en_i,
  input wire logic fail_en_i,
  input wire logic [4:0] fcmd_i,
  output logic fready_o,
  output logic fdone_o,
  output logic ffail_o,
  output logic [31:0] frdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  assign fready_o = ready_en_i && cnt == 0;
  assign fdone_o = cnt == 1;
  assign ffail_o = fdone_o && fail_en_i;
  // Data lines show a changed value when no answer is due
  assign frdata_o = fdone_o ? RDATA : ~RDATA;
  always @(posedge clk_i) begin
    if (reset_i)
      cnt <= 0;
    else if (fready_o && fcmd_i != 5'h00)
      cnt <= LAT;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
endmodule
`default_nettype wire

// ==== bench/flash_cmd_sva.sv ====
// Assertions on the APB and flash bus ports of the command block.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none
module flash_cmd_sva (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic fready_i,
  input wire logic [4:0] fcmd_o
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic tk;
  assign tk = psel_i & penable_i & !pready_o;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////
  chk_ready_next: assert property (tk |=> pready_o) else $error("ready late");
  chk_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready held");
  chk_idle_data: assert property (!pready_o |-> prdata_o == 32'h0) else $error("stray data");
  chk_id_upper: assert property (tk && !pwrite_i && paddr_i == 12'hFFC
    |=> prdata_o[31:8] == 24'h0 && !pslverr_o) else $error("id word");
  chk_status_busy: assert property (tk && !pwrite_i && paddr_i == 12'h00C && fcmd_o != 5'h00
    |=> prdata_o[1:0] != 2'h0) else $error("status idle");
  chk_cmd_hold: assert property (fcmd_o != 5'h00 && !fready_i |=> $stable(fcmd_o))
    else $error("command moved");
  chk_accept_idle: assert property (fcmd_o != 5'h00 && fready_i |=> fcmd_o == 5'h00)
    else $error("no idle");
  chk_unmapped_err: assert property (tk && paddr_i > 12'h018 && paddr_i < 12'hFFC
    |=> pslverr_o) else $error("no error");
  cover property (fcmd_o != 5'h00 && fready_i);
  cover property (tk && pwrite_i && paddr_i == 12'h000 && fcmd_o != 5'h00);
  cover property (pready_o && pslverr_o);
  // Command waiting on the bus while the flash bus is not ready
  cover property (fcmd_o != 5'h00 && !fready_i);
endmodule
bind apb_flash_command_issue flash_cmd_sva flash_cmd_sva_inst (.clk_i(clk_i),
  .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .fready_i(fready_i), .fcmd_o(fcmd_o));
`default_nettype wire

// ==== rtl/apb_flash_command_issue.v ====
// APB completer register file and command queue of the flash controller.
// Assumes APB requester on clk_i and a flash side bus on the same clock.
//
// Functional notes
// - Read-only word at 0xFFC, low byte holds preamble segment four, rest zero.
// - Status shows an active bit whenever a command is queued or executing.
// - Success or fail completion raises the matching pending flag.
// - Address and data written first; the command write queues the command.
// - Command, address, data writes blocked while command nonzero or flags pending.
// - Blocked write is dropped and the reject flag is raised.
// - Pending flags have no own address; readable via set and clear registers.
// - On acceptance by the flash bus, command clears and accept flag rises.
// - Without a queued command when the bus is ready, idle is issued.
// - Accept flag is raised for every command type.
// - Read data overwritten before accept flag serviced sets read overflow.
`default_nettype none
`include "flash_cmd_map.vh"

module apb_flash_command_issue #(
  parameter AW = 32,
  parameter DW = 32,
  // Arbitrary value for the preamble byte
  parameter [7:0] PREAMBLE_SEGMENT_FOUR = 8'h5A
) (
  input wire clk_i,
  input wire reset_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire fready_i,
  input wire fdone_i,
  input wire ffail_i,
  input wire [DW-1:0] frdata_i,
  output wire [`CMD_W-1:0] fcmd_o,
  output wire [AW-1:0] faddr_o,
  output wire [DW-1:0] fwdata_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  reg [`CMD_W-1:0] ctrl_q;
  reg [`CMD_W-1:0] ctrl_d;
  reg [AW-1:0] addr_q;
  reg [AW-1:0] addr_d;
  reg [DW-1:0] wdata_q;
  reg [DW-1:0] wdata_d;
  reg [DW-1:0] rdata_q;
  reg [DW-1:0] rdata_d;
  reg [`FLG_W-1:0] flags_q;
  reg [`FLG_W-1:0] flags_d;
  reg [`FLG_W-1:0] flag_set;
  reg [31:0] rd_word;
  reg rd_err;
  wire accept;
  wire busy;
  wire exec_read;
  wire [`CMD_W-1:0] fcmd;
  wire [AW-1:0] faddr;
  wire [DW-1:0] fwdata;

  // Widen a narrower field into a zero-filled bus word
  function [31:0] zext;
    input [31:0] v;
    input integer w;
    integer k;
    begin
      zext = 32'h0000_0000;
      for (k = 0; k < 32; k = k + 1) begin
        if (k < w) begin
          zext[k] = v[k];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: one wait state, answer registered

  wire access = psel_i && penable_i && !pready_o;
  wire wr = access && pwrite_i;
  wire hit_ctrl = (paddr_i == `OFS_CTRL);
  wire hit_addr = (paddr_i == `OFS_ADDR);
  wire hit_wdata = (paddr_i == `OFS_WDATA);
  wire hit_set = (paddr_i == `OFS_IRQ_SET);
  wire hit_clr = (paddr_i == `OFS_IRQ_CLR);
  wire cmd_reg_wr = wr && (hit_ctrl || hit_addr || hit_wdata);
  wire blocked = (ctrl_q != `CMD_IDLE) || (flags_q != `RST_FLAGS);
  wire [1:0] status_bits = {busy, ctrl_q != `CMD_IDLE};

  always @* begin
    rd_err = 1'b0;
    case (paddr_i)
      `OFS_CTRL: rd_word = zext({27'h0, ctrl_q}, `CMD_W);
      `OFS_ADDR: rd_word = zext(addr_q, AW);
      `OFS_WDATA: rd_word = zext(wdata_q, DW);
      `OFS_STATUS: rd_word = {30'h0, status_bits};
      `OFS_IRQ_SET: rd_word = {27'h0, flags_q};
      `OFS_IRQ_CLR: rd_word = {27'h0, flags_q};
      `OFS_RDATA: rd_word = zext(rdata_q, DW);
      `OFS_COMPONENT_ID_BYTE3: rd_word = {24'h0, PREAMBLE_SEGMENT_FOUR};
      default: begin
        rd_word = 32'h0000_0000;
        rd_err = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state of the programmers registers

  always @* begin
    ctrl_d = ctrl_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    flag_set = `RST_FLAGS;
    if (cmd_reg_wr && blocked) begin
      flag_set[`FLG_REJECT] = 1'b1;
    end else if (cmd_reg_wr) begin
      if (hit_ctrl) begin
        ctrl_d = pwdata_i[`CMD_W-1:0];
      end
      if (hit_addr) begin
        addr_d = pwdata_i[AW-1:0];
      end
      if (hit_wdata) begin
        wdata_d = pwdata_i[DW-1:0];
      end
    end
    if (accept) begin
      ctrl_d = `CMD_IDLE;
      flag_set[`FLG_ACCEPT] = 1'b1;
    end
    if (fdone_i) begin
      flag_set[`FLG_SUCCESS] = !ffail_i;
      flag_set[`FLG_FAIL] = ffail_i;
      if (exec_read && !ffail_i) begin
        rdata_d = frdata_i;
        if (flags_q[`FLG_ACCEPT]) begin
          flag_set[`FLG_RD_OVF] = 1'b1;
        end
      end
    end
    if (wr && hit_set) begin
      flag_set = flag_set | pwdata_i[`FLG_W-1:0];
    end
    // Hardware and software set win over the clear in the same cycle
    flags_d = flags_q;
    if (wr && hit_clr) begin
      flags_d = flags_q & ~pwdata_i[`FLG_W-1:0];
    end
    flags_d = flags_d | flag_set;
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_q <= `RST_CTRL;
      addr_q <= {AW{1'b0}};
      wdata_q <= {DW{1'b0}};
      rdata_q <= {DW{1'b0}};
      flags_q <= `RST_FLAGS;
      prdata_o <= `RST_WORD;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      flags_q <= flags_d;
      pready_o <= access;
      pslverr_o <= access && rd_err;
      prdata_o <= (access && !pwrite_i) ? rd_word : `RST_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash side issue

  flash_cmd_issue #(
    .AW(AW),
    .DW(DW)
  ) u_issue (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .cmd_i(ctrl_q),
    .addr_i(addr_q),
    .wdata_i(wdata_q),
    .fready_i(fready_i),
    .fdone_i(fdone_i),
    .fcmd_o(fcmd),
    .faddr_o(faddr),
    .fwdata_o(fwdata),
    .accept_o(accept),
    .busy_o(busy),
    .exec_read_o(exec_read)
  );

  assign fcmd_o = fcmd;
  assign faddr_o = faddr;
  assign fwdata_o = fwdata;

endmodule
`default_nettype wire

// ==== rtl/flash_cmd_issue.v ====
// Flash-side command issue: presents the queued command on the flash
// side bus, reports acceptance and tracks the command in execution.
// Assumes the flash side bus shares clk_i; fready_i is a same-clock level.
`default_nettype none
`include "flash_cmd_map.vh"

module flash_cmd_issue #(
  parameter AW = 32,
  parameter DW = 32
) (
  input wire clk_i,
  input wire reset_i,
  input wire [`CMD_W-1:0] cmd_i,
  input wire [AW-1:0] addr_i,
  input wire [DW-1:0] wdata_i,
  input wire fready_i,
  input wire fdone_i,
  output wire [`CMD_W-1:0] fcmd_o,
  output wire [AW-1:0] faddr_o,
  output wire [DW-1:0] fwdata_o,
  output wire accept_o,
  output wire busy_o,
  output wire exec_read_o
);

  reg [`CMD_W-1:0] fcmd_q;
  reg [AW-1:0] faddr_q;
  reg [DW-1:0] fwdata_q;
  reg busy_q;
  reg exec_read_q;

  assign fcmd_o = fcmd_q;
  assign faddr_o = faddr_q;
  assign fwdata_o = fwdata_q;
  assign busy_o = busy_q;
  assign exec_read_o = exec_read_q;

  // A command leaves the queue when it is on the bus and the bus is ready
  assign accept_o = (fcmd_q != `CMD_IDLE) && fready_i;

  always @(posedge clk_i) begin
    if (reset_i) begin
      fcmd_q <= `CMD_IDLE;
      faddr_q <= {AW{1'b0}};
      fwdata_q <= {DW{1'b0}};
      busy_q <= 1'b0;
      exec_read_q <= 1'b0;
    end else begin
      // Idle goes out whenever no new command is queued in time
      if (cmd_i != `CMD_IDLE && !accept_o) begin
        fcmd_q <= cmd_i;
        faddr_q <= addr_i;
        fwdata_q <= wdata_i;
      end else begin
        fcmd_q <= `CMD_IDLE;
      end
      if (accept_o) begin
        busy_q <= 1'b1;
        exec_read_q <= (fcmd_q == `CMD_READ);
      end else if (fdone_i) begin
        busy_q <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ==== rtl/flash_cmd_map.vh ====
// Register offsets, field positions, reset values and command codes
// for the flash command issue block. Definitions only.
`ifndef FLASH_CMD_MAP_VH
`define FLASH_CMD_MAP_VH

// Register byte offsets on the APB completer port
`define OFS_CTRL 12'h000
`define OFS_ADDR 12'h004
`define OFS_WDATA 12'h008
`define OFS_STATUS 12'h00C
`define OFS_IRQ_SET 12'h010
`define OFS_IRQ_CLR 12'h014
`define OFS_RDATA 12'h018
`define OFS_COMPONENT_ID_BYTE3 12'hFFC

// Command field width and codes
`define CMD_W 5
`define CMD_IDLE 5'h00
`define CMD_READ 5'h01
`define CMD_WRITE 5'h02
`define CMD_ROW_WRITE 5'h03

// Pending flag positions; bits [4:0] are the write-blocking set
`define FLG_W 5
`define FLG_SUCCESS 0
`define FLG_FAIL 1
`define FLG_REJECT 2
`define FLG_ACCEPT 3
`define FLG_RD_OVF 4

// Status register bit positions
`define ST_QUEUED 0
`define ST_EXEC 1

// Reset values
`define RST_CTRL 5'h00
`define RST_WORD 32'h0000_0000
`define RST_FLAGS 5'h00

`endif
